// File: design/packet_link_if.sv
// Signals between the register bank and its packet shift register.
// Assumes both ends run on the same system clock.
interface packet_link_if;
  logic baud_clock;
  logic data_bit;
  logic rearm;
  logic [7:0] length;
  logic [trim_pkg::PACKET_BITS-1:0] bits;
  logic [7:0] count;

  modport owner(output baud_clock, output data_bit, output rearm,
                output length, input bits, input count);
  modport shifter(input baud_clock, input data_bit, input rearm,
                  input length, output bits, output count);
endinterface

// File: design/packet_shifter.sv
// 128-bit received packet shift register.
// Assumes baud clock and data bit are synchronous to the system clock.
module packet_shifter (
  input wire logic clock_i,
  input wire logic rst_i,
  packet_link_if.shifter link
);

  logic baud_prev;
  logic baud_rise;
  logic [7:0] limit;
  logic active;

  // ==========================================================================
  // Baud clock edge and capture window
  assign baud_rise = link.baud_clock & ~baud_prev;
  assign limit = (link.length > trim_pkg::PACKET_MAX_LENGTH) ?
                 trim_pkg::PACKET_MAX_LENGTH : link.length;
  assign active = (link.length != trim_pkg::PACKET_LENGTH_OFF) &&
                  (link.count < limit);

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      baud_prev <= 1'b0;
    end else begin
      baud_prev <= link.baud_clock;
    end
  end

  // ==========================================================================
  // Shifting: earliest bit ends at the top after a full 128-bit packet
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      link.bits <= '0;
      link.count <= 8'h00;
    end else if (link.rearm) begin
      link.bits <= '0;
      link.count <= 8'h00;
    end else if (baud_rise && active) begin
      link.bits <= {link.bits[trim_pkg::PACKET_BITS-2:0],
                    link.data_bit};
      link.count <= link.count + 8'h01;
    end
  end

endmodule

// File: design/trim_config_and_packet_buffer.sv
// Trim, configuration and received-packet register bank of a transceiver.
// Assumes a classic Wishbone master on the system clock and a clock and
// data recovery block whose baud clock and data bit are synchronous to it.
//
// Function
// - Receiver bit 7 flags good oscillator calibration; bit 6 picks amp gain.
// - Synth loop bit 3 selects internal loop filter when set, else external.
// - Synth loop bits 2:0 charge-pump current, larger code more; 7:4 phase.
// - Antenna shunt control uses upper nibble in transmit, lower in receive.
// - Signal strength register holds slope 7:6, offset 5:4, resistor 3:0.
// - Analog test disable bit bypasses strength temperature compensation.
// - Discriminator register: filter bandwidth 7:4, offset 3:0, zero minimum.
// - IF filter register: centre code upper nibble, bandwidth lower nibble.
// - Crystal 7:4 bias current; low bits oscillator coarse and slope.
// - Misc upper nibble is plain user storage with no effect.
// - Misc bit 2 squelch, bit 1 cycle slip, bit 0 auto compensation.
// - Checksum register holds the nonvolatile array check value.
// - Nonvolatile writes permitted only while the key register holds 0x95.
// - Read-only register shows latest temperature conversion result.
// - Three read-only registers show channel 1, 2, 3 conversion results.
// - Packet bits captured only while packet length is non-zero.
// - Capture uses a 128-bit shift register fed by recovered data bit.
// - Shift register advances on recovered baud clock ticks only.
// - First received bit enters first, ends as MSB of first packet byte after 128 bits.
// - Packet length counts bits; zero disables, largest is 128.
module trim_config_and_packet_buffer (
  // System
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [9:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // Radio state and calibration
  input wire logic TRANSMIT_I,
  input wire logic CAL_DONE_I,
  input wire logic CAL_OK_I,
  // Conversion results
  input wire logic [7:0] TEMPERATURE_RESULT_I,
  input wire logic [7:0] CHANNEL1_RESULT_I,
  input wire logic [7:0] CHANNEL2_RESULT_I,
  input wire logic [7:0] CHANNEL3_RESULT_I,
  // Clock and data recovery
  input wire logic BAUD_CLOCK_I,
  input wire logic DATA_BIT_I,
  input wire logic PACKET_START_I,
  // Analog trims
  output logic [7:0] BIAS_REFERENCE_ADJUST_O,
  output logic [3:0] IF_CENTER_ADJUST_O,
  output logic [3:0] IF_BANDWIDTH_ADJUST_O,
  output logic FRONT_AMP_GAIN_SELECT_O,
  output logic [5:0] IMAGE_REJECT_AMPLITUDE_ADJUST_O,
  output logic [3:0] IMAGE_REJECT_PHASE_ADJUST_O,
  output logic INTERNAL_LOOP_FILTER_O,
  output logic [2:0] CHARGE_PUMP_CURRENT_O,
  output logic [3:0] ANTENNA_SHUNT_O,
  output logic [1:0] STRENGTH_SLOPE_O,
  output logic [1:0] STRENGTH_OFFSET_O,
  output logic [3:0] STRENGTH_RESISTOR_O,
  output logic STRENGTH_TEMP_BYPASS_O,
  output logic [3:0] DISCRIMINATOR_BANDWIDTH_O,
  output logic [3:0] DISCRIMINATOR_OFFSET_O,
  output logic [3:0] CRYSTAL_BIAS_ADJUST_O,
  output logic [3:0] QUICK_START_OSCILLATOR_TRIM_O,
  output logic [7:0] LNA_AND_TEMP_SENSOR_ADJUST_O,
  output logic [7:0] PROPORTIONAL_CURRENT_ADJUST_O,
  // Miscellaneous enables
  output logic DISCRIMINATOR_SQUELCH_ENABLE_O,
  output logic QUICK_START_OSCILLATOR_SLIP_ENABLE_O,
  output logic QUICK_START_OSCILLATOR_AUTO_COMP_O,
  // Nonvolatile memory
  output logic [7:0] NONVOLATILE_CHECKSUM_O,
  output logic NONVOLATILE_WRITE_ENABLE_O
);

  // ==========================================================================
  // Register storage
  logic [7:0] bias_reference_adjust;
  logic [7:0] if_filter_adjust;
  logic [7:0] receiver_adjust_status;
  logic [7:0] synth_loop_adjust;
  logic [7:0] antenna_capacitance_adjust;
  logic [7:0] signal_strength_adjust;
  logic [7:0] discriminator_offset_adjust;
  logic [7:0] crystal_current_adjust;
  logic [7:0] lna_and_temp_sensor_adjust;
  logic [7:0] proportional_current_adjust;
  logic [7:0] misc_config;
  logic [7:0] nonvolatile_checksum;
  logic [7:0] nonvolatile_write_key;
  logic [7:0] packet_length;
  logic [7:0] analog_test_mode;
  logic calibrated;

  // ==========================================================================
  // Bus decode
  logic access;
  logic write_strobe;
  logic [7:0] index;
  logic [7:0] next_read;

  assign access = CYC_I & STB_I & ~ACK_O;
  assign write_strobe = access & WE_I & SEL_I[0];
  assign index = ADR_I[9:2];

  // True when the current access writes the register at the given index.
  function automatic logic writes(input logic [7:0] target);
    writes = write_strobe && (index == target);
  endfunction

  // Byte of the packet buffer; byte 0 holds the top eight bits.
  function automatic logic [7:0] packet_byte(
    input logic [trim_pkg::PACKET_BITS-1:0] bits,
    input logic [7:0] position
  );
    logic [3:0] slot;
    slot = position[3:0];
    packet_byte = bits[(trim_pkg::PACKET_BITS - 1) - 8 * slot -: 8];
  endfunction

  // ==========================================================================
  // Packet shift register
  packet_link_if link ();

  assign link.baud_clock = BAUD_CLOCK_I;
  assign link.data_bit = DATA_BIT_I;
  assign link.length = packet_length;
  assign link.rearm = PACKET_START_I |
                      (write_strobe && (index == trim_pkg::IDX_PACKET_LENGTH));

  packet_shifter shifter (
    .clock_i(CLOCK_I),
    .rst_i(RST_I),
    .link(link)
  );

  // ==========================================================================
  // Adjustment registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      bias_reference_adjust <= trim_pkg::TRIM_RESET;
      if_filter_adjust <= trim_pkg::TRIM_RESET;
      receiver_adjust_status <= trim_pkg::TRIM_RESET;
      synth_loop_adjust <= trim_pkg::TRIM_RESET;
      antenna_capacitance_adjust <= trim_pkg::TRIM_RESET;
      signal_strength_adjust <= trim_pkg::TRIM_RESET;
      discriminator_offset_adjust <= trim_pkg::TRIM_RESET;
      crystal_current_adjust <= trim_pkg::TRIM_RESET;
      lna_and_temp_sensor_adjust <= trim_pkg::TRIM_RESET;
      proportional_current_adjust <= trim_pkg::TRIM_RESET;
    end else begin
      if (writes(trim_pkg::IDX_BIAS_REF)) begin
        bias_reference_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_IF_FILTER)) begin
        if_filter_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_RECEIVER)) begin
        receiver_adjust_status <= DAT_I[7:0] & trim_pkg::RX_WRITE_MASK;
      end
      if (writes(trim_pkg::IDX_SYNTH_LOOP)) begin
        synth_loop_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_ANTENNA)) begin
        antenna_capacitance_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_SIGNAL_STRENGTH)) begin
        signal_strength_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_DISCRIMINATOR)) begin
        discriminator_offset_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_CRYSTAL)) begin
        crystal_current_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_LNA_TEMP)) begin
        lna_and_temp_sensor_adjust <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_PROPORTIONAL)) begin
        proportional_current_adjust <= DAT_I[7:0];
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      misc_config <= trim_pkg::TRIM_RESET;
      nonvolatile_checksum <= trim_pkg::TRIM_RESET;
      nonvolatile_write_key <= trim_pkg::WRITE_KEY_RESET;
      packet_length <= trim_pkg::PACKET_LENGTH_OFF;
      analog_test_mode <= trim_pkg::TRIM_RESET;
    end else begin
      if (writes(trim_pkg::IDX_MISC)) begin
        misc_config <= DAT_I[7:0] & trim_pkg::MISC_WRITE_MASK;
      end
      if (writes(trim_pkg::IDX_CHECKSUM)) begin
        nonvolatile_checksum <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_WRITE_KEY)) begin
        nonvolatile_write_key <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_PACKET_LENGTH)) begin
        packet_length <= DAT_I[7:0];
      end
      if (writes(trim_pkg::IDX_ANALOG_TEST)) begin
        analog_test_mode <= DAT_I[7:0] & trim_pkg::ATEST_WRITE_MASK;
      end
    end
  end

  // ==========================================================================
  // Oscillator calibration status
  // Each completed calibration overwrites the flag with its own outcome.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      calibrated <= 1'b0;
    end else if (CAL_DONE_I) begin
      calibrated <= CAL_OK_I;
    end
  end

  // ==========================================================================
  // Read multiplexer
  always_comb begin
    next_read = 8'h00;
    case (index)
      trim_pkg::IDX_BIAS_REF: next_read = bias_reference_adjust;
      trim_pkg::IDX_IF_FILTER: next_read = if_filter_adjust;
      trim_pkg::IDX_RECEIVER: begin
        next_read = receiver_adjust_status;
        next_read[trim_pkg::RX_CALIBRATED_BIT] = calibrated;
      end
      trim_pkg::IDX_SYNTH_LOOP: next_read = synth_loop_adjust;
      trim_pkg::IDX_ANTENNA: next_read = antenna_capacitance_adjust;
      trim_pkg::IDX_SIGNAL_STRENGTH: next_read = signal_strength_adjust;
      trim_pkg::IDX_DISCRIMINATOR: next_read = discriminator_offset_adjust;
      trim_pkg::IDX_CRYSTAL: next_read = crystal_current_adjust;
      trim_pkg::IDX_LNA_TEMP: next_read = lna_and_temp_sensor_adjust;
      trim_pkg::IDX_PROPORTIONAL: next_read = proportional_current_adjust;
      trim_pkg::IDX_MISC: next_read = misc_config;
      trim_pkg::IDX_CHECKSUM: next_read = nonvolatile_checksum;
      trim_pkg::IDX_WRITE_KEY: next_read = nonvolatile_write_key;
      trim_pkg::IDX_PACKET_LENGTH: next_read = packet_length;
      trim_pkg::IDX_ANALOG_TEST: next_read = analog_test_mode;
      trim_pkg::IDX_TEMPERATURE: next_read = TEMPERATURE_RESULT_I;
      trim_pkg::IDX_CHANNEL1: next_read = CHANNEL1_RESULT_I;
      trim_pkg::IDX_CHANNEL2: next_read = CHANNEL2_RESULT_I;
      trim_pkg::IDX_CHANNEL3: next_read = CHANNEL3_RESULT_I;
      default: begin
        if (index >= trim_pkg::IDX_PACKET_FIRST &&
            index <= trim_pkg::IDX_PACKET_LAST) begin
          next_read = packet_byte(link.bits, index);
        end
      end
    endcase
  end

  // ==========================================================================
  // Bus answer
  // Every access, mapped or not, is acknowledged one cycle after it starts.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end else begin
      ACK_O <= access;
      if (access && !WE_I) begin
        DAT_O <= {24'h00_0000, next_read};
      end
    end
  end

  // ==========================================================================
  // Trim outputs
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ANTENNA_SHUNT_O <= 4'h0;
      STRENGTH_TEMP_BYPASS_O <= 1'b0;
      NONVOLATILE_WRITE_ENABLE_O <= 1'b0;
    end else begin
      ANTENNA_SHUNT_O <= TRANSMIT_I ? antenna_capacitance_adjust[7:4] :
                         antenna_capacitance_adjust[3:0];
      STRENGTH_TEMP_BYPASS_O <=
        analog_test_mode[trim_pkg::ATEST_TCOMP_OFF_BIT];
      NONVOLATILE_WRITE_ENABLE_O <=
        (nonvolatile_write_key == trim_pkg::NV_UNLOCK_KEY);
    end
  end

  assign BIAS_REFERENCE_ADJUST_O = bias_reference_adjust;
  assign IF_CENTER_ADJUST_O = if_filter_adjust[7:4];
  assign IF_BANDWIDTH_ADJUST_O = if_filter_adjust[3:0];
  assign FRONT_AMP_GAIN_SELECT_O =
    receiver_adjust_status[trim_pkg::RX_GAIN_BIT];
  assign IMAGE_REJECT_AMPLITUDE_ADJUST_O = receiver_adjust_status[5:0];
  assign IMAGE_REJECT_PHASE_ADJUST_O = synth_loop_adjust[7:4];
  assign INTERNAL_LOOP_FILTER_O =
    synth_loop_adjust[trim_pkg::SYNTH_FILTER_BIT];
  assign CHARGE_PUMP_CURRENT_O = synth_loop_adjust[2:0];
  assign STRENGTH_SLOPE_O = signal_strength_adjust[7:6];
  assign STRENGTH_OFFSET_O = signal_strength_adjust[5:4];
  assign STRENGTH_RESISTOR_O = signal_strength_adjust[3:0];
  assign DISCRIMINATOR_BANDWIDTH_O = discriminator_offset_adjust[7:4];
  assign DISCRIMINATOR_OFFSET_O = discriminator_offset_adjust[3:0];
  assign CRYSTAL_BIAS_ADJUST_O = crystal_current_adjust[7:4];
  assign QUICK_START_OSCILLATOR_TRIM_O = crystal_current_adjust[3:0];
  assign LNA_AND_TEMP_SENSOR_ADJUST_O = lna_and_temp_sensor_adjust;
  assign PROPORTIONAL_CURRENT_ADJUST_O = proportional_current_adjust;
  assign DISCRIMINATOR_SQUELCH_ENABLE_O =
    misc_config[trim_pkg::MISC_SQUELCH_BIT];
  assign QUICK_START_OSCILLATOR_SLIP_ENABLE_O =
    misc_config[trim_pkg::MISC_SLIP_BIT];
  assign QUICK_START_OSCILLATOR_AUTO_COMP_O =
    misc_config[trim_pkg::MISC_AUTO_COMP_BIT];
  assign NONVOLATILE_CHECKSUM_O = nonvolatile_checksum;

endmodule

// File: design/trim_pkg.sv
// Constants shared by the trim and packet buffer register bank.
// Assumes an 8-bit register index; byte address is four times the index.
package trim_pkg;

  // ==========================================================================
  // Register indexes
  localparam logic [7:0] IDX_BIAS_REF = 8'h54;
  localparam logic [7:0] IDX_IF_FILTER = 8'h55;
  localparam logic [7:0] IDX_RECEIVER = 8'h56;
  localparam logic [7:0] IDX_SYNTH_LOOP = 8'h57;
  localparam logic [7:0] IDX_ANTENNA = 8'h58;
  localparam logic [7:0] IDX_SIGNAL_STRENGTH = 8'h59;
  localparam logic [7:0] IDX_DISCRIMINATOR = 8'h5a;
  localparam logic [7:0] IDX_CRYSTAL = 8'h5b;
  localparam logic [7:0] IDX_LNA_TEMP = 8'h5c;
  localparam logic [7:0] IDX_PROPORTIONAL = 8'h5d;
  localparam logic [7:0] IDX_MISC = 8'h5e;
  localparam logic [7:0] IDX_CHECKSUM = 8'h5f;
  localparam logic [7:0] IDX_WRITE_KEY = 8'h60;
  localparam logic [7:0] IDX_PACKET_LENGTH = 8'h61;
  localparam logic [7:0] IDX_ANALOG_TEST = 8'h62;
  localparam logic [7:0] IDX_TEMPERATURE = 8'h6a;
  localparam logic [7:0] IDX_CHANNEL1 = 8'h6b;
  localparam logic [7:0] IDX_CHANNEL2 = 8'h6c;
  localparam logic [7:0] IDX_CHANNEL3 = 8'h6d;
  localparam logic [7:0] IDX_PACKET_FIRST = 8'h70;
  localparam logic [7:0] IDX_PACKET_LAST = 8'h7f;

  // ==========================================================================
  // Reset values and keys
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam logic [7:0] WRITE_KEY_RESET = 8'h00;
  localparam logic [7:0] NV_UNLOCK_KEY = 8'h95;

  // ==========================================================================
  // Field positions and masks
  localparam int RX_CALIBRATED_BIT = 7;
  localparam int RX_GAIN_BIT = 6;
  localparam logic [7:0] RX_WRITE_MASK = 8'h7f;
  localparam int SYNTH_FILTER_BIT = 3;
  localparam int MISC_SQUELCH_BIT = 2;
  localparam int MISC_SLIP_BIT = 1;
  localparam int MISC_AUTO_COMP_BIT = 0;
  localparam logic [7:0] MISC_WRITE_MASK = 8'hf7;
  localparam int ATEST_TCOMP_OFF_BIT = 0;
  localparam logic [7:0] ATEST_WRITE_MASK = 8'h01;

  // ==========================================================================
  // Packet buffer
  localparam int PACKET_BITS = 128;
  localparam logic [7:0] PACKET_MAX_LENGTH = 8'h80;
  localparam logic [7:0] PACKET_LENGTH_OFF = 8'h00;

endpackage

// File: tb/trim_bank_monitor.sv
// Bus and trim output checks for the trim and packet register bank.
// Assumes a classic Wishbone master that holds its request until ack.
module trim_bank_monitor (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // Register bus
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [9:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  // Watched pins
  input wire logic TRANSMIT_I,
  input wire logic [7:0] TEMPERATURE_RESULT_I,
  input wire logic INTERNAL_LOOP_FILTER_O,
  input wire logic [2:0] CHARGE_PUMP_CURRENT_O,
  input wire logic [3:0] ANTENNA_SHUNT_O,
  input wire logic STRENGTH_TEMP_BYPASS_O,
  input wire logic DISCRIMINATOR_SQUELCH_ENABLE_O,
  input wire logic NONVOLATILE_WRITE_ENABLE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // ==========================================================================
  // Sequences
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_wr(logic [7:0] idx);
    ACK_O && WE_I && SEL_I[0] && ADR_I[9:2] == idx;
  endsequence
  // ==========================================================================
  // Properties
  property p_ack_pulse;
    s_req |=> ACK_O ##1 !ACK_O;
  endproperty
  property p_ack_cause;
    ACK_O |-> $past(CYC_I && STB_I);
  endproperty
  property p_synth;
    s_wr(trim_pkg::IDX_SYNTH_LOOP) |-> INTERNAL_LOOP_FILTER_O == DAT_I[3]
      && CHARGE_PUMP_CURRENT_O == DAT_I[2:0];
  endproperty
  property p_misc;
    s_wr(trim_pkg::IDX_MISC) |-> DISCRIMINATOR_SQUELCH_ENABLE_O == DAT_I[2];
  endproperty
  property p_shunt;
    s_wr(trim_pkg::IDX_ANTENNA) |=> ANTENNA_SHUNT_O == ($past(TRANSMIT_I)
      ? $past(DAT_I[7:4]) : $past(DAT_I[3:0]));
  endproperty
  property p_bypass;
    s_wr(trim_pkg::IDX_ANALOG_TEST) |=>
      STRENGTH_TEMP_BYPASS_O == $past(DAT_I[0]);
  endproperty
  property p_key;
    s_wr(trim_pkg::IDX_WRITE_KEY) |=> NONVOLATILE_WRITE_ENABLE_O ==
      ($past(DAT_I[7:0]) == trim_pkg::NV_UNLOCK_KEY);
  endproperty
  property p_temp;
    ACK_O && !WE_I && ADR_I[9:2] == trim_pkg::IDX_TEMPERATURE
      |-> DAT_O[7:0] == $past(TEMPERATURE_RESULT_I);
  endproperty
  property p_hold;
    !(ACK_O && !WE_I) |-> $stable(DAT_O) && DAT_O[31:8] == 24'h000000;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack not one pulse");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_synth: assert property (p_synth)
    else $error("synth loop pins wrong");
  a_misc: assert property (p_misc)
    else $error("squelch pin wrong");
  a_shunt: assert property (p_shunt)
    else $error("antenna shunt wrong");
  a_bypass: assert property (p_bypass)
    else $error("bypass pin wrong");
  a_key: assert property (p_key)
    else $error("write enable wrong");
  a_temp: assert property (p_temp)
    else $error("temperature read wrong");
  a_hold: assert property (p_hold)
    else $error("read data moved");
endmodule

bind trim_config_and_packet_buffer trim_bank_monitor u_mon (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
  .ACK_O(ACK_O), .TRANSMIT_I(TRANSMIT_I),
  .TEMPERATURE_RESULT_I(TEMPERATURE_RESULT_I),
  .INTERNAL_LOOP_FILTER_O(INTERNAL_LOOP_FILTER_O),
  .CHARGE_PUMP_CURRENT_O(CHARGE_PUMP_CURRENT_O),
  .ANTENNA_SHUNT_O(ANTENNA_SHUNT_O),
  .STRENGTH_TEMP_BYPASS_O(STRENGTH_TEMP_BYPASS_O),
  .DISCRIMINATOR_SQUELCH_ENABLE_O(DISCRIMINATOR_SQUELCH_ENABLE_O),
  .NONVOLATILE_WRITE_ENABLE_O(NONVOLATILE_WRITE_ENABLE_O));

// File: tb/trim_config_and_packet_buffer_tb_top.sv
// Self-checking bench for the trim and packet register bank.
// Assumes the bank answers each bus access with a one-cycle ack.
module trim_config_and_packet_buffer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic tx = 1'b0, cdone = 1'b0, cok = 1'b0;
  logic baud = 1'b0, dbit = 1'b0, pstart = 1'b0;
  logic [7:0] tmp = 8'h00, ch1 = 8'h00, ch2 = 8'h00, ch3 = 8'h00;
  logic [7:0] bias, lna, ipt, csum;
  logic [3:0] ifc, ifb, ph, ant, res, dbw, doff, xb, quick_start_oscillator;
  logic [5:0] iramp;
  logic [2:0] cp;
  logic [1:0] slope, offs;
  logic gain, ilf, byp, sq, slip, acomp, nvwe;
  logic [127:0] pkt = 128'hc3a5_0f96_1e2d_3c4b_5a69_7887_96a5_b4c3;
  logic [15:0] q = 16'hb3c5;
  int fail_count = 0, checks = 0;
  always #2 clk = ~clk;
  trim_config_and_packet_buffer uut (
    .CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .TRANSMIT_I(tx), .CAL_DONE_I(cdone), .CAL_OK_I(cok),
    .TEMPERATURE_RESULT_I(tmp), .CHANNEL1_RESULT_I(ch1),
    .CHANNEL2_RESULT_I(ch2), .CHANNEL3_RESULT_I(ch3),
    .BAUD_CLOCK_I(baud), .DATA_BIT_I(dbit), .PACKET_START_I(pstart),
    .BIAS_REFERENCE_ADJUST_O(bias), .IF_CENTER_ADJUST_O(ifc),
    .IF_BANDWIDTH_ADJUST_O(ifb), .FRONT_AMP_GAIN_SELECT_O(gain),
    .IMAGE_REJECT_AMPLITUDE_ADJUST_O(iramp),
    .IMAGE_REJECT_PHASE_ADJUST_O(ph), .INTERNAL_LOOP_FILTER_O(ilf),
    .CHARGE_PUMP_CURRENT_O(cp), .ANTENNA_SHUNT_O(ant),
    .STRENGTH_SLOPE_O(slope), .STRENGTH_OFFSET_O(offs),
    .STRENGTH_RESISTOR_O(res), .STRENGTH_TEMP_BYPASS_O(byp),
    .DISCRIMINATOR_BANDWIDTH_O(dbw), .DISCRIMINATOR_OFFSET_O(doff),
    .CRYSTAL_BIAS_ADJUST_O(xb), .QUICK_START_OSCILLATOR_TRIM_O(quick_start_oscillator),
    .LNA_AND_TEMP_SENSOR_ADJUST_O(lna),
    .PROPORTIONAL_CURRENT_ADJUST_O(ipt),
    .DISCRIMINATOR_SQUELCH_ENABLE_O(sq),
    .QUICK_START_OSCILLATOR_SLIP_ENABLE_O(slip),
    .QUICK_START_OSCILLATOR_AUTO_COMP_O(acomp),
    .NONVOLATILE_CHECKSUM_O(csum), .NONVOLATILE_WRITE_ENABLE_O(nvwe));
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      give_verdict();
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, r);
    chk(r, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Baud stays high two cycles so only its rising edge may shift.
  task automatic send(input logic b);
    @(posedge clk);
    baud <= 1'b1;
    dbit <= b;
    wait_cyc(2);
    baud <= 1'b0;
    dbit <= ~b;
  endtask
  task automatic pulse_cal(input logic ok);
    @(posedge clk);
    cdone <= 1'b1;
    cok <= ok;
    @(posedge clk);
    cdone <= 1'b0;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_trims;
    rd(8'h60, 8'h00);
    for (int i = 0; i < 10; i++) wr(8'h54 + i[7:0], 8'ha5 ^ i[7:0]);
    for (int i = 0; i < 10; i++)
      rd(8'h54 + i[7:0], i == 2 ? 8'h27 : 8'ha5 ^ i[7:0]);
    chk({ifc, ifb}, 8'ha4);
    chk({gain, iramp}, 7'h27);
    chk({ph, ilf, cp}, 8'ha6);
    chk({slope, offs, res}, 8'ha0);
    chk({dbw, doff}, 8'ha3);
    chk({xb, quick_start_oscillator}, 8'ha2);
    chk({bias, lna, ipt}, 24'ha5adac);
    wr(8'h5f, 8'h3c);
    chk(csum, 8'h3c);
    for (int c = 0; c < 8; c++) begin
      wr(8'h57, {4'h0, c[0], c[2:0]});
      chk({ilf, cp}, {c[0], c[2:0]});
    end
  endtask
  task automatic t_misc;
    wr(8'h5e, 8'haf);
    rd(8'h5e, 8'ha7);
    chk({sq, slip, acomp}, 3'h7);
    wr(8'h5e, 8'h52);
    chk({sq, slip, acomp}, 3'h2);
    rd(8'h5e, 8'h52);
  endtask
  task automatic t_ant_bypass;
    wr(8'h58, 8'h3c);
    wait_cyc(2);
    chk(ant, 4'hc);
    tx <= 1'b1;
    wait_cyc(3);
    chk(ant, 4'h3);
    tx <= 1'b0;
    wr(8'h62, 8'hff);
    rd(8'h62, 8'h01);
    chk(byp, 1'b1);
    wr(8'h62, 8'h00);
    wait_cyc(2);
    chk(byp, 1'b0);
  endtask
  task automatic t_key;
    wr(8'h60, 8'h95);
    wait_cyc(2);
    chk(nvwe, 1'b1);
    wr(8'h60, 8'h94);
    wait_cyc(2);
    chk(nvwe, 1'b0);
    wr(8'h60, 8'h95);
    wr(8'h60, 8'h00);
    wait_cyc(2);
    chk(nvwe, 1'b0);
  endtask
  task automatic t_adc_cal;
    tmp <= 8'h1e;
    ch1 <= 8'h2d;
    ch2 <= 8'h3c;
    ch3 <= 8'h4b;
    for (int i = 0; i < 4; i++) wr(8'h6a + i[7:0], 8'hff);
    for (int i = 0; i < 4; i++)
      rd(8'h6a + i[7:0], 8'h1e + 8'h0f * i[7:0]);
    wr(8'h63, 8'h5a);
    rd(8'h63, 8'h00);
    pulse_cal(1'b1);
    rd(8'h56, 8'ha7);
    wr(8'h56, 8'h40);
    chk(gain, 1'b1);
    rd(8'h56, 8'hc0);
    pulse_cal(1'b0);
    rd(8'h56, 8'h40);
  endtask
  task automatic t_packet;
    wr(8'h61, 8'h00);
    for (int i = 0; i < 8; i++) send(1'b1);
    rd(8'h7f, 8'h00);
    wr(8'h61, 8'h80);
    for (int i = 127; i >= 0; i--) send(pkt[i]);
    for (int k = 0; k < 16; k++)
      rd(8'h70 + k[7:0], pkt[127 - 8 * k -: 8]);
    for (int i = 0; i < 3; i++) send(~pkt[i]);
    rd(8'h7f, pkt[7:0]);
    rd(8'h70, pkt[127:120]);
    wr(8'h61, 8'h0c);
    for (int i = 15; i >= 0; i--) send(q[i]);
    rd(8'h7e, {4'h0, q[15:12]});
    rd(8'h7f, q[11:4]);
    pstart <= 1'b1;
    @(posedge clk);
    pstart <= 1'b0;
    rd(8'h7f, 8'h00);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    wait_cyc(12);
    rst <= 1'b0;
    t_trims();
    t_misc();
    t_ant_bypass();
    t_key();
    t_adc_cal();
    t_packet();
    give_verdict();
  end
endmodule
